// >>> two_channel_pwm_timer.v
// Added by the designer: the strobed register port.
`include "pwm_timer_defs.vh"
`default_nettype none

// How it works
// R1: Running channel keeps new period buffered until period end, counter write, disable.
// R2: Disabled channel: period write loads buffer and active latch together.
// R3: Period and duty reads return last written value.
// R4: Output period is clock times period, doubled when center aligned.
// R5: Running channel keeps new duty buffered until period end, counter write, disable.
// R6: Disabled channel: duty write loads buffer and active latch together.
// R7: Counter equal to active duty toggles the output flip-flop.
// R8: Polarity one starts high then falls; zero starts low then rises.
// R9: Prescaled clocks A and B divide by 1 to 128 via 3-bit fields.
// R10: Prescale counter stops while both channels are disabled.
// R11: Scaled clock from 8-bit reloading down counter, then halved.
// R12: Scale value zero counts as 256, dividing by 512.
// R13: Writing a scale register reloads its down counter at once; here it loads the scale value held before the write.
// R14: Per-channel select: channel 0 A or SA, channel 1 B or SB.
// R15: Each channel has 8-bit counter, period and duty; period match ends cycle.
// R16: Software should not change scale or clock select while running.
// R17: Left: count 0 to period-1; center: up to period, down to 0.
// R18: Counter write clears, sets up, loads latches, sets output by polarity.
// R19: Center-align bit set selects center aligned, cleared left aligned.
// R20: Per-channel enable; counter holds while cleared, resumes when set.
module two_channel_pwm_timer #(
    parameter NCH = 2
) (
    // Clock and reset
    input  wire           mclk,
    input  wire           rst_n,
    // Register port
    input  wire [7:0]     reg_addr,
    input  wire [7:0]     reg_wdata,
    input  wire           reg_wr,
    input  wire           reg_rd,
    output reg  [7:0]     reg_rdata,
    // Waveform outputs
    output reg  [NCH-1:0] pwm_out
);
    // ************************************************************
    // Control registers
    // ************************************************************
    reg  [7:0]     ctl_r;
    reg  [7:0]     pre_r;
    reg  [7:0]     scl_a_r;
    reg  [7:0]     scl_b_r;
    reg  [6:0]     pre_cnt_r;

    wire [NCH-1:0] en      = ctl_r[`CTL_EN_LSB +: NCH];
    wire [NCH-1:0] pol     = ctl_r[`CTL_POL_LSB +: NCH];
    wire [NCH-1:0] cae     = ctl_r[`CTL_CAE_LSB +: NCH];
    wire [NCH-1:0] clk_sel = ctl_r[`CTL_CLK_LSB +: NCH];

    wire wr_ctl  = reg_wr && (reg_addr == `OFS_WAVE_CTRL);
    wire wr_pre  = reg_wr && (reg_addr == `OFS_PRESCALE);
    wire wr_sa   = reg_wr && (reg_addr == `OFS_SCALE_A);
    wire wr_sb   = reg_wr && (reg_addr == `OFS_SCALE_B);

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_r   <= `RST_BYTE;
            pre_r   <= `RST_BYTE;
            scl_a_r <= `RST_BYTE;
            scl_b_r <= `RST_BYTE;
        end else begin
            if (wr_ctl)
                ctl_r <= reg_wdata;
            if (wr_pre)
                pre_r <= reg_wdata & `PRE_MASK;
            if (wr_sa)
                scl_a_r <= reg_wdata;
            if (wr_sb)
                scl_b_r <= reg_wdata;
        end
    end

    // ************************************************************
    // Prescaler
    // ************************************************************
    // Free counter gated off when no channel runs, saving power
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            pre_cnt_r <= 7'h00;
        else if (|en)
            pre_cnt_r <= pre_cnt_r + 7'h01; // R10
    end

    wire [2:0] sel_a = pre_r[`PRE_A_LSB +: `PRE_W];
    wire [2:0] sel_b = pre_r[`PRE_B_LSB +: `PRE_W];

    // Tick when all low bits below the selected divide are ones
    function tick_of;
        input [2:0] sel;
        input [6:0] cnt;
        reg   [7:0] msk;
        begin
            msk     = (8'h01 << sel) - 8'h01;
            tick_of = ((cnt & msk[6:0]) == msk[6:0]);
        end
    endfunction

    wire tick_a = (|en) && tick_of(sel_a, pre_cnt_r); // R9
    wire tick_b = (|en) && tick_of(sel_b, pre_cnt_r); // R9
    wire tick_sa;
    wire tick_sb;

    scaled_clock_gen u_scale_a (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .tick_in   (tick_a),
        .scale_val (scl_a_r),
        .reload    (wr_sa),
        .tick_out  (tick_sa)
    );

    scaled_clock_gen u_scale_b (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .tick_in   (tick_b),
        .scale_val (scl_b_r),
        .reload    (wr_sb),
        .tick_out  (tick_sb)
    );

    // ************************************************************
    // Channel timers
    // ************************************************************
    reg  [7:0] cnt_r    [0:NCH-1];
    reg  [7:0] per_buf_r[0:NCH-1];
    reg  [7:0] dty_buf_r[0:NCH-1];
    reg  [7:0] per_act_r[0:NCH-1];
    reg  [7:0] dty_act_r[0:NCH-1];
    reg  [NCH-1:0] down_r;
    reg  [NCH-1:0] en_d_r;

    wire [NCH-1:0] ch_tick;
    assign ch_tick[0] = clk_sel[0] ? tick_sa : tick_a; // R14
    assign ch_tick[1] = clk_sel[1] ? tick_sb : tick_b; // R14

    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_ch
            localparam [31:0] A_CNT = `OFS_CNT0 + g;
            localparam [31:0] A_PER = `OFS_PERIOD0 + g;
            localparam [31:0] A_DTY = `OFS_DUTY0 + g;
            wire wr_cnt = reg_wr && ({24'h0, reg_addr} == A_CNT);
            wire wr_per = reg_wr && ({24'h0, reg_addr} == A_PER);
            wire wr_dty = reg_wr && ({24'h0, reg_addr} == A_DTY);
            wire step   = en[g] && ch_tick[g];
            // Left aligned ends at period-1; center ends back at zero
            wire left_end = (cnt_r[g] + 8'h01 == per_act_r[g]) ||
                            (per_act_r[g] == 8'h00); // R17
            wire ctr_end  = down_r[g] && (cnt_r[g] <= 8'h01); // R17
            wire per_end  = step && (cae[g] ? ctr_end : left_end); // R4
            wire turn     = cae[g] && !down_r[g] && (cnt_r[g] + 8'h01 >= per_act_r[g]);
            wire [7:0] cnt_nxt = (cae[g] && down_r[g]) ? cnt_r[g] - 8'h01 :
                                 (turn ? per_act_r[g] : cnt_r[g] + 8'h01);
            // Disable edge also commits the buffers
            wire load     = wr_cnt || per_end || (en_d_r[g] && !en[g]);

            always @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    cnt_r[g]     <= `RST_BYTE;
                    per_buf_r[g] <= `RST_BYTE;
                    dty_buf_r[g] <= `RST_BYTE;
                    per_act_r[g] <= `RST_BYTE;
                    dty_act_r[g] <= `RST_BYTE;
                    down_r[g]    <= 1'b0;
                    en_d_r[g]    <= 1'b0;
                    pwm_out[g]   <= 1'b0;
                end else begin
                    en_d_r[g] <= en[g];
                    if (wr_per)
                        per_buf_r[g] <= reg_wdata; // R3
                    if (wr_dty)
                        dty_buf_r[g] <= reg_wdata; // R3
                    if (load) begin
                        per_act_r[g] <= wr_per ? reg_wdata : per_buf_r[g]; // R1 R18
                        dty_act_r[g] <= wr_dty ? reg_wdata : dty_buf_r[g]; // R5 R18
                    end else begin
                        if (wr_per && !en[g])
                            per_act_r[g] <= reg_wdata; // R2
                        if (wr_dty && !en[g])
                            dty_act_r[g] <= reg_wdata; // R6
                    end
                    if (wr_cnt || per_end) begin
                        cnt_r[g]   <= 8'h00; // R18 R15
                        down_r[g]  <= 1'b0;
                        pwm_out[g] <= pol[g]; // R8
                    end else if (step) begin // R20
                        if (turn)
                            down_r[g] <= 1'b1; // R19
                        cnt_r[g] <= cnt_nxt;
                        // Toggle as the count arrives at duty, not one tick later
                        if (cnt_nxt == dty_act_r[g])
                            pwm_out[g] <= ~pwm_out[g]; // R7
                    end
                end
            end
        end
    endgenerate

    // ************************************************************
    // Read port
    // ************************************************************
    reg [7:0] rd_nxt;
    always @* begin
        case (reg_addr)
            `OFS_WAVE_CTRL: rd_nxt = ctl_r;
            `OFS_PRESCALE:  rd_nxt = pre_r;
            `OFS_SCALE_A:   rd_nxt = scl_a_r;
            `OFS_SCALE_B:   rd_nxt = scl_b_r;
            `OFS_CNT0:      rd_nxt = cnt_r[0];
            `OFS_CNT1:      rd_nxt = cnt_r[1];
            `OFS_PERIOD0:   rd_nxt = per_buf_r[0]; // R3
            `OFS_PERIOD1:   rd_nxt = per_buf_r[1]; // R3
            `OFS_DUTY0:     rd_nxt = dty_buf_r[0]; // R3
            `OFS_DUTY1:     rd_nxt = dty_buf_r[1]; // R3
            default:        rd_nxt = `RST_BYTE;
        endcase
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            reg_rdata <= `RST_BYTE;
        else if (reg_rd)
            reg_rdata <= rd_nxt;
        else
            reg_rdata <= `RST_BYTE;
    end
endmodule // two_channel_pwm_timer

`default_nettype wire

// >>> pwm_timer_defs.vh
`ifndef PWM_TIMER_DEFS_VH
`define PWM_TIMER_DEFS_VH

// ************************************************************
// Register offsets
// ************************************************************
`define OFS_WAVE_CTRL    8'h60
`define OFS_PRESCALE     8'h61
`define OFS_SCALE_A      8'h62
`define OFS_SCALE_B      8'h63
`define OFS_CNT0         8'h64
`define OFS_CNT1         8'h65
`define OFS_PERIOD0      8'h66
`define OFS_PERIOD1      8'h67
`define OFS_DUTY0        8'h68
`define OFS_DUTY1        8'h69

// ************************************************************
// Waveform control fields
// ************************************************************
`define CTL_EN_LSB       0
`define CTL_POL_LSB      2
`define CTL_CAE_LSB      4
`define CTL_CLK_LSB      6

// ************************************************************
// Prescale fields and reset values
// ************************************************************
`define PRE_A_LSB        0
`define PRE_B_LSB        4
`define PRE_W            3
`define PRE_MASK         8'h77
`define RST_BYTE         8'h00
`define SCALE_ONE        8'h01

`endif

// >>> scaled_clock_gen.v
`include "pwm_timer_defs.vh"
`default_nettype none

// ************************************************************
// Scaled clock: reloadable down counter then divide by two
// ************************************************************
module scaled_clock_gen (
    // Clock and reset
    input  wire       mclk,
    input  wire       rst_n,
    // Control
    input  wire       tick_in,
    input  wire [7:0] scale_val,
    input  wire       reload,
    // Output tick
    output reg        tick_out
);
    reg  [7:0] down_r;
    reg        half_r;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            down_r   <= `RST_BYTE;
            half_r   <= 1'b0;
            tick_out <= 1'b0;
        end else begin
            tick_out <= 1'b0;
            if (reload) begin
                down_r <= scale_val; // R13
            end else if (tick_in) begin
                // Zero behaves as 256: it wraps to 8'hff first
                if (down_r == `SCALE_ONE) begin // R11 R12
                    down_r <= scale_val;
                    half_r <= ~half_r;
                    tick_out <= half_r;
                end else begin
                    down_r <= down_r - 8'h01;
                end
            end
        end
    end
endmodule // scaled_clock_gen

`default_nettype wire

// >>> pwm_timer_chk.sv
`include "pwm_timer_defs.vh"
`default_nettype none
// ****************************************
// Register port and waveform checker
// ****************************************
module pwm_timer_chk #(
    parameter NCH = 2
) (
    // Clock and reset
    input wire logic           mclk,
    input wire logic           rst_n,
    // Register port
    input wire logic [7:0]     reg_addr,
    input wire logic [7:0]     reg_wdata,
    input wire logic           reg_wr,
    input wire logic           reg_rd,
    input wire logic [7:0]     reg_rdata,
    // Waveforms
    input wire logic [NCH-1:0] pwm_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] shadow_r [0:3];
    logic [7:0] ctl_r;
    logic [7:0] exp_r;
    wire        hit = reg_addr >= `OFS_PERIOD0 && reg_addr <= `OFS_DUTY1;
    // Low address bits are unique across the four buffered registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) shadow_r[i] <= 8'h00;
            ctl_r <= 8'h00;
            exp_r <= 8'h00;
        end else begin
            if (reg_wr && hit) shadow_r[reg_addr[1:0]] <= reg_wdata;
            if (reg_wr && reg_addr == `OFS_WAVE_CTRL) ctl_r <= reg_wdata;
            exp_r <= shadow_r[reg_addr[1:0]];
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
    property p_readback; reg_rd && hit |=> reg_rdata == exp_r; endproperty
    property p_unmapped; reg_rd && reg_addr == 8'h7f |=> reg_rdata == 8'h00; endproperty
    property p_cnt_pol0;
        reg_wr && reg_addr == `OFS_CNT0 |=> pwm_out[0] == ctl_r[`CTL_POL_LSB];
    endproperty
    property p_cnt_pol1;
        reg_wr && reg_addr == `OFS_CNT1 |=> pwm_out[1] == ctl_r[`CTL_POL_LSB+1];
    endproperty
    // Three quiet cycles allow for enable synchronisation
    property p_hold0; (!ctl_r[0] && !reg_wr) [*3] |=> $stable(pwm_out[0]); endproperty
    property p_hold1; (!ctl_r[1] && !reg_wr) [*3] |=> $stable(pwm_out[1]); endproperty
    property p_rst_out; $rose(rst_n) |-> pwm_out == '0 && reg_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    a_readback: assert property (p_readback) else $error("readback differs");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_cnt_pol0: assert property (p_cnt_pol0) else $error("ch0 counter write level");
    a_cnt_pol1: assert property (p_cnt_pol1) else $error("ch1 counter write level");
    a_hold0: assert property (p_hold0) else $error("ch0 moved while disabled");
    a_hold1: assert property (p_hold1) else $error("ch1 moved while disabled");
    a_rst_out: assert property (p_rst_out) else $error("outputs not cleared by reset");
    c_read: cover property (reg_rd && hit);
    c_rise0: cover property ($rose(pwm_out[0]));
    c_fall1: cover property ($fell(pwm_out[1]));
endmodule // pwm_timer_chk
bind two_channel_pwm_timer pwm_timer_chk #(.NCH(NCH)) u_pwm_timer_chk (.mclk(mclk),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_out(pwm_out));
`default_nettype wire

// >>> tb_top.sv
`include "pwm_timer_defs.vh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       mclk = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [1:0] pwm_out;
    int         n_mismatch = 0;
    int         comparisons = 0;
    int         hi, per, n, sc;
    always #2.5 mclk = ~mclk;
    two_channel_pwm_timer #(.NCH(2)) u_two_channel_pwm_timer (.mclk(mclk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pwm_out(pwm_out));
    // ****************************************
    // Shared tasks
    // ****************************************
    task give_verdict;
        $display("Counts: %0d mismatches, %0d comparisons", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task rchk(input string name, input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(name, {8'h00, reg_rdata}, {8'h00, e});
    endtask
    task wait_lvl(input int ch, input logic v, output int cnt);
        cnt = 0;
        while (pwm_out[ch] !== v) begin
            @(posedge mclk);
            #1;
            cnt++;
            if (cnt > 20000) begin
                n_mismatch++;
                $display("[ERR] pwm_out wait expected level %0d", v);
                give_verdict();
            end
        end
    endtask
    // Rise to fall is the high time, rise to rise the period
    task meas(input int ch, output int h, output int p);
        int m;
        wait_lvl(ch, 1'b0, m);
        wait_lvl(ch, 1'b1, m);
        wait_lvl(ch, 1'b0, h);
        wait_lvl(ch, 1'b1, m);
        p = h + m;
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        for (int a = 8'h60; a <= 8'h69; a++) rchk("reset value", a[7:0], 8'h00);
        wr(`OFS_PERIOD0, 8'h10);
        wr(`OFS_DUTY0, 8'h08);
        wr(`OFS_PERIOD1, 8'h04);
        wr(`OFS_DUTY1, 8'h01);
        rchk("period_ch0", `OFS_PERIOD0, 8'h10);
        rchk("duty_ch1", `OFS_DUTY1, 8'h01);
        rchk("unmapped", 8'h7f, 8'h00);
        $display("Test registers done");
        wr(`OFS_WAVE_CTRL, 8'h04);
        wr(`OFS_CNT0, 8'h00);
        wr(`OFS_WAVE_CTRL, 8'h05);
        meas(0, hi, per);
        chk("left high", hi, 16'd8);
        chk("left period", per, 16'd16);
        // Six edges of register traffic pass before counting starts
        wait_lvl(0, 1'b0, n);
        wait_lvl(0, 1'b1, n);
        wr(`OFS_DUTY0, 8'h0c);
        wr(`OFS_PERIOD0, 8'h18);
        rchk("period buffer", `OFS_PERIOD0, 8'h18);
        wait_lvl(0, 1'b0, hi);
        chk("old high", hi + 6, 16'd8);
        wait_lvl(0, 1'b1, n);
        chk("old period", hi + 6 + n, 16'd16);
        meas(0, hi, per);
        chk("new high", hi, 16'd12);
        chk("new period", per, 16'd24);
        $display("Test left aligned done");
        for (int s = 0; s < 8; s++) begin
            wr(`OFS_PRESCALE, s[7:0]);
            meas(0, hi, per);
            meas(0, hi, per);
            chk("prescale period", per, 24 << s);
        end
        $display("Test prescale done");
        wr(`OFS_WAVE_CTRL, 8'h00);
        wr(`OFS_PRESCALE, 8'h00);
        wr(`OFS_PERIOD0, 8'h04);
        wr(`OFS_DUTY0, 8'h02);
        wr(`OFS_WAVE_CTRL, 8'h45);
        for (int i = 0; i < 3; i++) begin
            sc = (i == 0) ? 1 : (i == 1) ? 3 : 0;
            wr(`OFS_WAVE_CTRL, 8'h00);
            wr(`OFS_SCALE_A, sc[7:0]);
            wr(`OFS_WAVE_CTRL, 8'h45);
            meas(0, hi, per);
            meas(0, hi, per);
            chk("scaled period", per, 8 * ((sc == 0) ? 256 : sc));
        end
        $display("Test scaled clock done");
        wr(`OFS_WAVE_CTRL, 8'h22);
        meas(1, hi, per);
        chk("center high", hi, 16'd6);
        chk("center period", per, 16'd8);
        $display("Test center aligned done");
        for (int ch = 0; ch < 2; ch++) begin
            for (int p = 0; p < 2; p++) begin
                wr(`OFS_WAVE_CTRL, 8'(p << (2 + ch)));
                wr(8'(`OFS_CNT0 + ch), 8'hff);
                chk("counter write level", {15'h0, pwm_out[ch]}, p);
                rchk("counter cleared", 8'(`OFS_CNT0 + ch), 8'h00);
            end
        end
        $display("Test counter write done");
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
